// ### mtq_cfg.svh
// Constants of the melody tone queue: link codes, host register map, timing
`ifndef MTQ_CFG_SVH
`define MTQ_CFG_SVH

// Link address and register codes, note, queue and scale limits
`define MTQ_WR_ADDR        8'h78
`define MTQ_RD_ADDR        8'h79
`define MTQ_MELODY_REG     8'h09
`define MTQ_CLEAR_BYTE     8'hff
`define MTQ_FREE_RESET     8'h0a
`define MTQ_NOTE_BYTES     4
`define MTQ_QUEUE_NOTES    10
`define MTQ_FIFO_DEPTH     16
`define MTQ_SCALE_LAST     8'h3b

// Timing: one time step is 4 ms, tone reference tick is 500 kHz, clock 250 MHz
`define MTQ_CLK_HZ         250000000
`define MTQ_STEP_US        4000
`define MTQ_TONE_REF_HZ    500000
`define MTQ_STEP_CYCLES    ((`MTQ_STEP_US) * ((`MTQ_CLK_HZ) / 1000000))
`define MTQ_REF_CYCLES     ((`MTQ_CLK_HZ) / (`MTQ_TONE_REF_HZ))

// Host register map (APB byte addresses) and fields
`define MTQ_HOST_NOTE      8'h00
`define MTQ_HOST_CMD       8'h04
`define MTQ_HOST_STATUS    8'h08
`define MTQ_CMD_CLEAR_BIT  0
`define MTQ_CMD_QUERY_BIT  1
`define MTQ_STAT_BUSY_BIT  0
`define MTQ_STAT_FREE_LSB  8

// Pin select bits
`define MTQ_SOUND_SEL_BIT  5
`define MTQ_POWER_SEL_BIT  4

`endif

// ### mtq_pkg.sv
// Types of the melody tone queue, each used by one of its two ends
package mtq_pkg;

  typedef struct packed {
    logic [7:0] scale;
    logic [7:0] tone_time;
    logic [7:0] mid_time;
    logic [7:0] tail_time;
  } mtq_note_t;

  typedef enum logic [2:0] {
    LK_IDLE,
    LK_ADDR,
    LK_REG,
    LK_DATA,
    LK_READ,
    LK_SKIP
  } mtq_link_st_t;

  typedef enum logic [1:0] {
    PL_IDLE,
    PL_TONE,
    PL_TAIL
  } mtq_play_st_t;

  typedef enum logic [2:0] {
    H_IDLE,
    H_START,
    H_SEND,
    H_STOP,
    H_RSTART,
    H_RADDR,
    H_RWAIT
  } mtq_host_st_t;

endpackage

// ### mtq_if.sv
// Byte link between the host controller and the melody device
`timescale 1ns/1ps
interface mtq_if;
  logic       start;
  logic       stop;
  logic       valid;
  logic [7:0] data;
  logic       rd_valid;
  logic [7:0] rd_data;

  modport dev (
    input  start,
    input  stop,
    input  valid,
    input  data,
    output rd_valid,
    output rd_data
  );

  modport host (
    output start,
    output stop,
    output valid,
    output data,
    input  rd_valid,
    input  rd_data
  );
endinterface

// ### mtq_device.sv
// Melody device end: note queue, link decoder, tone and power generator
//
// Contract
// [R1] Note is four bytes: scale, tone, mid, tail
// [R2] Note cut short by stop is discarded
// [R3] Full queue drops incoming notes, keeps queued
// [R4] Queue holds ten complete notes
// [R5] Read returns free entries, ten after reset
// [R6] Time fields 0..255, 4 ms per unit
// [R7] Note lasts tone time plus tail time
// [R8] Only octave-3 A to octave-8 G sharp
// [R9] Scale index 0 to 59, semitone steps
// [R10] Index selects fixed divisor, A4 is 440 Hz
// [R11] Single 0xFF byte stops play, empties queue
// [R12] Host writes 0x78, 0x09, then notes
// [R13] Host reads free space with 0x79
// [R14] Select bit 5 makes sound pin tone
// [R15] Enable bit 4 makes power pin; others ignored
// [R16] Power pin high only while tone sounds
// [R17] Tone toggles at half divisor of ticks
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "mtq_cfg.svh"

module mtq_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = `MTQ_FIFO_DEPTH
) (
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       flush,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [$clog2(DEPTH+1)-1:0] count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != DEPTH[$clog2(DEPTH+1)-1:0]) && !flush;
  assign out_valid = (count_reg != '0) && !flush;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign count     = count_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + push - pop;
    end
  end
endmodule

module mtq_device #(
  parameter int QUEUE_NOTES = `MTQ_QUEUE_NOTES,
  parameter int FIFO_DEPTH  = `MTQ_FIFO_DEPTH,
  parameter int STEP_CYCLES = `MTQ_STEP_CYCLES,
  parameter int REF_CYCLES  = `MTQ_REF_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  mtq_if.dev              link,
  input  wire logic [7:0] sound_pin_select,
  input  wire logic [7:0] sound_power_enable,
  output logic            sound_channel_pin,
  output logic            power_channel_pin,
  output logic            playing
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // Divisors of a 500 kHz reference, one per semitone from octave-3 A
  localparam logic [11:0] DIV_TABLE [0:59] = '{ // R10
    12'h8e1, 12'h861, 12'h7e9, 12'h777, 12'h70c, 12'h6a7, 12'h647, 12'h5ed, 12'h598, 12'h547,
    12'h4fc, 12'h4b4, 12'h470, 12'h431, 12'h3f4, 12'h3bc, 12'h386, 12'h353, 12'h324, 12'h2f6,
    12'h2cc, 12'h2a4, 12'h27e, 12'h25a, 12'h238, 12'h218, 12'h1fa, 12'h1de, 12'h1c3, 12'h1aa,
    12'h192, 12'h17b, 12'h166, 12'h152, 12'h13f, 12'h12d, 12'h11c, 12'h10c, 12'h0fd, 12'h0ef,
    12'h0e1, 12'h0d5, 12'h0c9, 12'h0be, 12'h0b3, 12'h0a9, 12'h09f, 12'h096, 12'h08e, 12'h086,
    12'h07f, 12'h077, 12'h071, 12'h06a, 12'h064, 12'h05f, 12'h059, 12'h054, 12'h050, 12'h04b
  };

  mtq_pkg::mtq_link_st_t lk_reg;
  mtq_pkg::mtq_play_st_t pl_reg;
  mtq_pkg::mtq_note_t    push_note;
  mtq_pkg::mtq_note_t    pop_note;
  logic [7:0]            regsel_reg;
  logic [1:0]            byte_idx_reg;
  logic [23:0]           note_hold_reg;
  logic                  rd_valid_reg;
  logic [7:0]            rd_data_reg;
  logic                  data_byte;
  logic                  clear_hit;
  logic                  room;
  logic                  push_valid;
  logic                  push_ready;
  logic                  pop_valid;
  logic                  pop_ready;
  logic [CW-1:0]         fifo_count;
  logic [7:0]            free_cnt;
  logic [11:0]           div_reg;
  logic [7:0]            tone_left_reg;
  logic [7:0]            tail_left_reg;
  logic [31:0]           step_cnt_reg;
  logic                  step_end;
  logic [31:0]           ref_cnt_reg;
  logic [11:0]           half_cnt_reg;
  logic                  tone_reg;
  logic                  sound_pin_reg;
  logic                  power_pin_reg;

  // Bytes aimed at the melody register, outside any start or stop cycle
  assign data_byte = link.valid && !link.start && !link.stop && lk_reg == mtq_pkg::LK_DATA
                     && regsel_reg == `MTQ_MELODY_REG;
  assign clear_hit = data_byte && byte_idx_reg == 2'd0 && link.data == `MTQ_CLEAR_BYTE; // R11
  assign room      = fifo_count < CW'(QUEUE_NOTES); // R4
  assign free_cnt  = 8'(QUEUE_NOTES) - 8'(fifo_count); // R5

  assign push_note  = {note_hold_reg, link.data}; // R1
  // Fourth byte completes a note; full queue or scale past the table drops it
  assign push_valid = data_byte && byte_idx_reg == 2'(`MTQ_NOTE_BYTES - 1) && room
                      && note_hold_reg[23:16] <= `MTQ_SCALE_LAST; // R3 R8 R9

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lk_reg        <= mtq_pkg::LK_IDLE;
      regsel_reg    <= `MTQ_MELODY_REG;
      byte_idx_reg  <= 2'd0;
      note_hold_reg <= 24'h00_0000;
    end else if (link.start) begin
      lk_reg       <= mtq_pkg::LK_ADDR;
      byte_idx_reg <= 2'd0;
    end else if (link.stop) begin
      lk_reg       <= mtq_pkg::LK_IDLE;
      byte_idx_reg <= 2'd0; // R2
    end else if (link.valid) begin
      case (lk_reg)
        mtq_pkg::LK_ADDR: begin
          if (link.data == `MTQ_WR_ADDR) begin
            lk_reg <= mtq_pkg::LK_REG;
          end else if (link.data == `MTQ_RD_ADDR) begin
            lk_reg <= mtq_pkg::LK_READ;
          end else begin
            lk_reg <= mtq_pkg::LK_SKIP;
          end
        end
        mtq_pkg::LK_REG: begin
          regsel_reg <= link.data;
          lk_reg     <= mtq_pkg::LK_DATA;
        end
        mtq_pkg::LK_DATA: begin
          if (clear_hit) begin
            lk_reg <= mtq_pkg::LK_SKIP;
          end else if (data_byte) begin
            note_hold_reg <= {note_hold_reg[15:0], link.data}; // R1
            byte_idx_reg  <= byte_idx_reg + 2'd1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read answer one cycle after the read address byte
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= `MTQ_FREE_RESET;
    end else begin
      rd_valid_reg <= link.valid && !link.start && !link.stop && lk_reg == mtq_pkg::LK_ADDR
                      && link.data == `MTQ_RD_ADDR;
      rd_data_reg  <= (regsel_reg == `MTQ_MELODY_REG) ? free_cnt : 8'h00; // R5
    end
  end

  assign link.rd_valid = rd_valid_reg;
  assign link.rd_data  = rd_data_reg;

  mtq_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .flush     (clear_hit),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_note),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_note),
    .count     (fifo_count)
  );

  // Player drains only when idle, so the queue really backs up
  assign pop_ready = pl_reg == mtq_pkg::PL_IDLE && !clear_hit;
  assign step_end  = step_cnt_reg == 32'(STEP_CYCLES - 1); // R6

  always_ff @(posedge mclk) begin
    if (sys_rst || clear_hit) begin // R11
      pl_reg        <= mtq_pkg::PL_IDLE;
      div_reg       <= DIV_TABLE[0];
      tone_left_reg <= 8'h00;
      tail_left_reg <= 8'h00;
    end else begin
      case (pl_reg)
        mtq_pkg::PL_IDLE: begin
          if (pop_valid) begin
            div_reg       <= DIV_TABLE[pop_note.scale[5:0]]; // R10
            tone_left_reg <= pop_note.tone_time;
            tail_left_reg <= pop_note.tail_time;
            if (pop_note.tone_time != 8'h00) begin
              pl_reg <= mtq_pkg::PL_TONE;
            end else if (pop_note.tail_time != 8'h00) begin
              pl_reg <= mtq_pkg::PL_TAIL;
            end
          end
        end
        mtq_pkg::PL_TONE: begin
          if (step_end) begin
            tone_left_reg <= tone_left_reg - 8'd1;
            if (tone_left_reg == 8'd1) begin
              pl_reg <= (tail_left_reg != 8'h00) ? mtq_pkg::PL_TAIL : mtq_pkg::PL_IDLE; // R7
            end
          end
        end
        mtq_pkg::PL_TAIL: begin
          if (step_end) begin
            tail_left_reg <= tail_left_reg - 8'd1;
            if (tail_left_reg == 8'd1) begin
              pl_reg <= mtq_pkg::PL_IDLE; // R7
            end
          end
        end
        default: begin
          pl_reg <= mtq_pkg::PL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || pl_reg == mtq_pkg::PL_IDLE || step_end) begin
      step_cnt_reg <= 32'h0000_0000;
    end else begin
      step_cnt_reg <= step_cnt_reg + 32'd1; // R6
    end
  end

  // Square wave: ref tick counter, toggle after half the divisor in ticks
  always_ff @(posedge mclk) begin
    if (sys_rst || pl_reg != mtq_pkg::PL_TONE) begin
      ref_cnt_reg  <= 32'h0000_0000;
      half_cnt_reg <= 12'h000;
      tone_reg     <= 1'b0;
    end else if (ref_cnt_reg == 32'(REF_CYCLES - 1)) begin
      ref_cnt_reg <= 32'h0000_0000;
      if (half_cnt_reg == (div_reg >> 1) - 12'd1) begin // R17
        half_cnt_reg <= 12'h000;
        tone_reg     <= !tone_reg;
      end else begin
        half_cnt_reg <= half_cnt_reg + 12'd1;
      end
    end else begin
      ref_cnt_reg <= ref_cnt_reg + 32'd1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sound_pin_reg <= 1'b0;
      power_pin_reg <= 1'b0;
    end else begin
      // Gated by state as well, so a clear silences the pin two cycles after the clear byte, one cycle after the state goes idle
      sound_pin_reg <= sound_pin_select[`MTQ_SOUND_SEL_BIT] && tone_reg && pl_reg == mtq_pkg::PL_TONE; // R14 R17
      power_pin_reg <= sound_power_enable[`MTQ_POWER_SEL_BIT] && pl_reg == mtq_pkg::PL_TONE; // R15 R16
    end
  end

  assign sound_channel_pin = sound_pin_reg;
  assign power_channel_pin = power_pin_reg;
  assign playing           = pl_reg != mtq_pkg::PL_IDLE;
endmodule

// ### mtq_host.sv
// Host controller end: APB registers drive note, clear and query transactions
`timescale 1ns/1ps
`include "mtq_cfg.svh"

module mtq_host (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  mtq_if.host              link
);
  mtq_pkg::mtq_host_st_t st_reg;
  logic [31:0]           note_reg;
  logic [47:0]           tx_buf_reg;
  logic [2:0]            tx_left_reg;
  logic                  query_reg;
  logic [7:0]            free_reg;
  logic [31:0]           prdata_reg;
  logic                  wr_acc;
  logic                  busy;
  logic                  mapped;

  assign busy    = st_reg != mtq_pkg::H_IDLE;
  assign mapped  = paddr == `MTQ_HOST_NOTE || paddr == `MTQ_HOST_CMD || paddr == `MTQ_HOST_STATUS;
  assign wr_acc  = psel && penable && pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_reg;

  // Read data captured in the setup cycle so it is steady in the access phase
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `MTQ_HOST_NOTE:   prdata_reg <= note_reg;
        `MTQ_HOST_STATUS: prdata_reg <= {16'h0000, free_reg, 7'h00, busy};
        default:          prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Orders written while busy are ignored; status shows busy
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg      <= mtq_pkg::H_IDLE;
      note_reg    <= 32'h0000_0000;
      tx_buf_reg  <= 48'h0000_0000_0000;
      tx_left_reg <= 3'd0;
      query_reg   <= 1'b0;
      free_reg    <= `MTQ_FREE_RESET;
    end else begin
      case (st_reg)
        mtq_pkg::H_IDLE: begin
          if (wr_acc && paddr == `MTQ_HOST_NOTE) begin
            note_reg    <= pwdata;
            tx_buf_reg  <= {`MTQ_WR_ADDR, `MTQ_MELODY_REG, pwdata}; // R12 R1
            tx_left_reg <= 3'd6;
            st_reg      <= mtq_pkg::H_START;
          end else if (wr_acc && paddr == `MTQ_HOST_CMD && pwdata[`MTQ_CMD_CLEAR_BIT]) begin
            tx_buf_reg  <= {`MTQ_WR_ADDR, `MTQ_MELODY_REG, `MTQ_CLEAR_BYTE, 24'h00_0000}; // R11
            tx_left_reg <= 3'd3;
            st_reg      <= mtq_pkg::H_START;
          end else if (wr_acc && paddr == `MTQ_HOST_CMD && pwdata[`MTQ_CMD_QUERY_BIT]) begin
            tx_buf_reg  <= {`MTQ_WR_ADDR, `MTQ_MELODY_REG, 32'h0000_0000}; // R13
            tx_left_reg <= 3'd2;
            query_reg   <= 1'b1;
            st_reg      <= mtq_pkg::H_START;
          end
        end
        mtq_pkg::H_START: begin
          st_reg <= mtq_pkg::H_SEND;
        end
        mtq_pkg::H_SEND: begin
          tx_buf_reg  <= {tx_buf_reg[39:0], 8'h00};
          tx_left_reg <= tx_left_reg - 3'd1;
          if (tx_left_reg == 3'd1) begin
            st_reg <= mtq_pkg::H_STOP;
          end
        end
        mtq_pkg::H_STOP: begin
          if (query_reg) begin
            tx_buf_reg <= {`MTQ_RD_ADDR, 40'h00_0000_0000}; // R13
            st_reg     <= mtq_pkg::H_RSTART;
          end else begin
            st_reg <= mtq_pkg::H_IDLE;
          end
        end
        mtq_pkg::H_RSTART: begin
          st_reg <= mtq_pkg::H_RADDR;
        end
        mtq_pkg::H_RADDR: begin
          st_reg <= mtq_pkg::H_RWAIT;
        end
        mtq_pkg::H_RWAIT: begin
          if (link.rd_valid) begin
            free_reg  <= link.rd_data;
            query_reg <= 1'b0;
            st_reg    <= mtq_pkg::H_STOP;
          end
        end
        default: begin
          st_reg <= mtq_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign link.start = st_reg == mtq_pkg::H_START || st_reg == mtq_pkg::H_RSTART;
  assign link.stop  = st_reg == mtq_pkg::H_STOP;
  assign link.valid = st_reg == mtq_pkg::H_SEND || st_reg == mtq_pkg::H_RADDR;
  assign link.data  = tx_buf_reg[47:40];
endmodule

// ### mtq_assertions.sv
// Concurrent checks on the host-to-device link and the device pins
`timescale 1ns/1ps
module mtq_assertions (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       start,
  input wire logic       stop,
  input wire logic       valid,
  input wire logic [7:0] data,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] sound_pin_select,
  input wire logic [7:0] sound_power_enable,
  input wire logic       sound_channel_pin,
  input wire logic       power_channel_pin,
  input wire logic       playing
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Position of the next byte in the transaction; 0 is the address byte
  logic [7:0] pos_reg;
  logic       byte_ok;
  logic       slot0;
  assign byte_ok = valid && !start && !stop;
  assign slot0   = pos_reg >= 8'h02 && pos_reg[1:0] == 2'b10;

  always_ff @(posedge mclk) begin
    if (sys_rst || start) begin
      pos_reg <= 8'h00;
    end else if (byte_ok) begin
      pos_reg <= pos_reg + 8'h01;
    end
  end

  AST_READ_ANSWER: assert property (byte_ok && pos_reg == 8'h00 && data == 8'h79 |=> rd_valid)
    else $error("read answer missing after read address");
  AST_READ_CAUSE: assert property (rd_valid |-> $past(byte_ok && pos_reg == 8'h00 && data == 8'h79))
    else $error("read answer without read address");
  AST_RESET_FREE: assert property ($fell(sys_rst) |-> rd_data == 8'h0a)
    else $error("free count not ten after reset");
  AST_FREE_LIMIT: assert property (rd_data <= 8'h0a)
    else $error("free count above ten");
  AST_FREE_STEP: assert property (rd_data != $past(rd_data) |-> rd_data == $past(rd_data) - 8'h01
    || rd_data == $past(rd_data) + 8'h01 || rd_data == 8'h0a)
    else $error("free count jumped");
  AST_ONE_EVENT: assert property ($onehot0({start, stop, valid}))
    else $error("start, stop and byte overlap");
  AST_START_ADDR: assert property (start |=> byte_ok && (data == 8'h78 || data == 8'h79))
    else $error("no address byte after start");
  AST_REG_BYTE: assert property (byte_ok && pos_reg == 8'h00 && data == 8'h78 |=> byte_ok && data == 8'h09)
    else $error("register byte missing after write address");
  AST_NOTE_WHOLE: assert property (stop |-> pos_reg inside {8'h01, 8'h02, 8'h03, 8'h06})
    else $error("transaction ended with a partial note");
  AST_CLEAR: assert property (byte_ok && slot0 && data == 8'hff |=> !playing
    ##1 (rd_data == 8'h0a && !power_channel_pin && !sound_channel_pin))
    else $error("clear did not stop play and empty queue");
  AST_POWER_PLAY: assert property (power_channel_pin |-> $past(playing))
    else $error("power pin high while idle");
  AST_SOUND_SEL: assert property (!sound_pin_select[5] |=> !sound_channel_pin)
    else $error("tone on pin while not selected");
  AST_POWER_SEL: assert property (!sound_power_enable[4] |=> !power_channel_pin)
    else $error("power pin high while not enabled");

  cover property (rd_valid);
  cover property (byte_ok && slot0 && data == 8'hff);
  cover property ($rose(power_channel_pin));
endmodule

// ### melody_tone_queue_test.sv
// Bench: APB-driven host joined to a device, and a second device driven byte by byte
`timescale 1ns/1ps
`include "mtq_cfg.svh"
module melody_tone_queue_test;
  localparam int STEP = 600;
  localparam int REF  = 2;
  logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, rerr, rv;
  logic        snd, pwr, play, play2;
  logic [7:0]  paddr, sel, pwr_en, rdd;
  logic [31:0] pwdata, prdata, rdat;
  int          fail_count, num_checks;
  mtq_if link ();
  mtq_if link2 ();
  mtq_host mtq_host_inst (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
  mtq_device #(.STEP_CYCLES(STEP), .REF_CYCLES(REF)) mtq_device_inst (.mclk(mclk), .sys_rst(sys_rst),
    .link(link.dev), .sound_pin_select(sel), .sound_power_enable(pwr_en), .sound_channel_pin(snd),
    .power_channel_pin(pwr), .playing(play));
  // Second device lets the bench break the framing that the host never breaks
  mtq_device #(.STEP_CYCLES(STEP), .REF_CYCLES(REF)) mtq_device_fault_inst (.mclk(mclk), .sys_rst(sys_rst),
    .link(link2.dev), .sound_pin_select(8'hff), .sound_power_enable(8'hff), .sound_channel_pin(),
    .power_channel_pin(), .playing(play2));
  mtq_assertions mtq_assertions_inst (.mclk(mclk), .sys_rst(sys_rst), .start(link.start), .stop(link.stop),
    .valid(link.valid), .data(link.data), .rd_valid(link.rd_valid), .rd_data(link.rd_data),
    .sound_pin_select(sel), .sound_power_enable(pwr_en), .sound_channel_pin(snd),
    .power_channel_pin(pwr), .playing(play));

  always #2 mclk = ~mclk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    fail_count++;
    $display("[FAIL] wait expected done seen timeout");
    end_sim();
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timed_out();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll until the host has finished its link transaction
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `MTQ_HOST_STATUS, 32'h0);
      n++;
    end while (rdat[0] !== 1'b0 && n < 200);
    if (n >= 200) timed_out();
  endtask

  task automatic note(input logic [31:0] w);
    idle();
    apb(1'b1, `MTQ_HOST_NOTE, w);
  endtask

  task automatic free(input logic [7:0] exp);
    idle();
    apb(1'b1, `MTQ_HOST_CMD, 32'h2);
    idle();
    chk("free", {24'h0, exp}, {24'h0, rdat[15:8]});
  endtask

  function automatic logic sig(input int k);
    return k == 0 ? pwr : (k == 1 ? play : snd);
  endfunction

  // Counts edges until signal k shows level v
  task automatic upto(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
    if (n >= lim) timed_out();
  endtask

  task automatic l2(input logic [2:0] ssv, input logic [7:0] d);
    @(posedge mclk);
    rv = link2.rd_valid;
    rdd = link2.rd_data;
    {link2.start, link2.stop, link2.valid} <= ssv;
    link2.data <= d;
  endtask

  task automatic l2rd(input logic [7:0] exp);
    l2(3'b100, 8'h00);
    l2(3'b001, `MTQ_RD_ADDR);
    l2(3'b010, 8'h00);
    l2(3'b000, 8'h00);
    chk("rd_valid", 32'h1, {31'h0, rv});
    chk("rd_data", {24'h0, exp}, {24'h0, rdd});
  endtask

  task automatic s_reset();
    apb(1'b0, `MTQ_HOST_STATUS, 32'h0);
    chk("status", 32'h0000_0a00, rdat & 32'h0000_ff01);
    chk("link_free", 32'h0a, {24'h0, link.rd_data});
    apb(1'b0, 8'h0c, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
  endtask

  task automatic s_tone();
    logic [7:0] idx[3] = '{8'h00, 8'h0c, 8'h3b};
    int         dv[3] = '{2273, 1136, 75};
    int         n;
    logic       s;
    for (int i = 0; i < 3; i++) begin
      note({idx[i], 8'h0c, 16'h0});
      upto(0, 1'b1, 100, n);
      s = snd;
      upto(2, ~s, 3000, n);
      s = snd;
      upto(2, ~s, 3000, n);
      chk("half_period", (dv[i] >> 1) * REF, n);
      upto(1, 1'b0, 9000, n);
    end
  endtask

  task automatic s_len();
    int a;
    int b;
    note(32'h3b01_ff02);
    fork
      begin
        upto(0, 1'b1, 100, a);
        upto(0, 1'b0, 2000, a);
      end
      begin
        upto(1, 1'b1, 100, b);
        upto(1, 1'b0, 4000, b);
      end
    join
    chk("tone_len", STEP, a);
    chk("note_len", 3 * STEP, b);
  endtask

  task automatic s_fill();
    int n;
    note(32'h3bc8_0000);
    upto(1, 1'b1, 100, n);
    for (int i = 1; i <= 10; i++) begin
      note(32'h3b01_0001);
      free(8'(10 - i));
      if (i == 5) begin
        note(32'h3c01_0001);
        free(8'h05);
      end
    end
    note(32'h0001_0001);
    free(8'h00);
    @(posedge mclk);
    sel <= 8'hdf;
    pwr_en <= 8'hef;
    repeat (3) @(posedge mclk);
    chk("sound_off", 32'h0, {31'h0, snd});
    chk("power_off", 32'h0, {31'h0, pwr});
    sel <= 8'h20;
    pwr_en <= 8'h10;
    repeat (3) @(posedge mclk);
    chk("power_on", 32'h1, {31'h0, pwr});
    idle();
    apb(1'b1, `MTQ_HOST_CMD, 32'h1);
    free(8'h0a);
    chk("playing", 32'h0, {31'h0, play});
  endtask

  // Two whole notes then three stray bytes cut off by stop
  task automatic s_fault();
    logic [7:0] b[13] = '{8'h78, 8'h09, 8'h00, 8'hc8, 8'h00, 8'h00, 8'h00, 8'hc8, 8'h00, 8'h00,
                          8'h3b, 8'h01, 8'h00};
    logic [7:0] z[5] = '{8'h70, 8'h00, 8'h0c, 8'h00, 8'h00};
    l2(3'b100, 8'h00);
    foreach (b[i]) l2(3'b001, b[i]);
    l2(3'b010, 8'h00);
    // A foreign address byte must leave the rest of its transaction unused
    l2(3'b100, 8'h00);
    foreach (z[i]) l2(3'b001, z[i]);
    l2(3'b010, 8'h00);
    l2rd(8'h09);
    l2(3'b100, 8'h00);
    l2(3'b001, `MTQ_WR_ADDR);
    l2(3'b001, 8'h05);
    l2(3'b010, 8'h00);
    l2rd(8'h00);
    l2(3'b100, 8'h00);
    l2(3'b001, `MTQ_WR_ADDR);
    l2(3'b001, `MTQ_MELODY_REG);
    l2(3'b001, `MTQ_CLEAR_BYTE);
    l2(3'b010, 8'h00);
    l2rd(8'h0a);
    chk("playing2", 32'h0, {31'h0, play2});
  endtask

  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sel = 8'h20;
    pwr_en = 8'h10;
    {link2.start, link2.stop, link2.valid} = 3'b000;
    link2.data = 8'h00;
    fail_count = 0;
    num_checks = 0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    s_reset();
    s_tone();
    s_len();
    s_fill();
    s_fault();
    end_sim();
  end
endmodule
